// file: sec_pkg.sv
// Purpose: shared constants for the status event collector
// Assumes: 24-bit status word, msb first as laid out below
// Notes: mask is active high (1 blocks the bit)
package sec_pkg;
	localparam int STAT_W = 24;
	localparam int MODE_W = 4;
	localparam int NPIN = 4;
	// status bit positions
	localparam int BIT_DSUP_A = 23;
	localparam int BIT_DSUP_B = 22;
	localparam int BIT_ASUP = 21;
	localparam int BIT_DONE = 20;
	localparam int BIT_FIFO = 19;
	localparam int BIT_ACC = 18;
	localparam int BIT_UPPER = 17;
	localparam int BIT_LOWER = 16;
	localparam int POS_AN_RISE = 12;
	localparam int POS_AN_FALL = 8;
	localparam int POS_DG_RISE = 4;
	localparam int POS_DG_FALL = 0;
	localparam logic [23:0] STATUS_RESET = 24'h00_0000;
	localparam logic [23:0] MASK_RESET = 24'hFF_FFFF;
	// power-up view of the two digital supply flags
	localparam logic [23:0] STATUS_POWERUP = 24'hC0_0000;
	// digital pin modes handled here
	localparam logic [3:0] MODE_SWITCH2 = 4'hD;
	localparam logic [3:0] MODE_READY = 4'hE;
	localparam logic [3:0] MODE_GEN_OUT = 4'hF;
	// ready pin low time: one converter master clock, here one ref_clk
	localparam int READY_GAP_CYC = 1;
endpackage : sec_pkg

// file: sec_collector.sv
// Purpose: event status register, interrupt, and digital pin output modes
// Assumes: status read framed by stat_rd_start/stat_rd_end/stat_rd_abort
// Notes: pins arrive asynchronous and are double-registered here
//
// Overview of operation
// RULE_01 - pin in second-switch mode is an input driving switch 2 control
// RULE_02 - ready mode: pin goes high once a result is written
// RULE_03 - ready mode: reading result or status returns pin low
// RULE_04 - if already high, a new result drops pin low one cycle
// RULE_05 - output mode: pin follows its logic-level bit
// RULE_06 - one 24-bit status register gathers all sub-block flags
// RULE_07 - interrupt asserts when any set status bit is unmasked
// RULE_08 - recurring event keeps bit and interrupt set, no toggle
// RULE_09 - successful status read clears all bits, per-bit conditions apply
// RULE_10 - flag updates during a status read are applied after it
// RULE_11 - supply flags clear on read only if the low condition ended
// RULE_12 - powered-down supply monitor keeps its flag and cannot set; code clears that flag on a completed read (keep gated by mon_enable)
// RULE_13 - digital supply flags show set after power-up until first read
// RULE_14 - done flag sets on result write, clears on status or result read
// RULE_15 - fifo flag sets at threshold, clears on status or fifo access
// RULE_16 - accumulator flag sets when full, clears on status or acc access
// RULE_17 - alarm flags clear on status read or own threshold write
// RULE_18 - analog pins keep rise and fall flags, cleared by status read
// RULE_19 - digital pins keep rise and fall flags, cleared by status read
// RULE_20 - mask bits reset to one; cleared mask lets bit interrupt
// RULE_21 - interrupt released at read start, reasserts on abort or new event
// RULE_22 - pins synchronised before edge detection, one flag per edge
`timescale 1ns/1ps
module sec_collector (
	input wire logic ref_clk, // 100 MHz system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic stat_rd_start, // status read recognised (pulse)
	input wire logic stat_rd_end, // status read completed (pulse)
	input wire logic stat_rd_abort, // status read aborted (pulse)
	input wire logic [23:0] int_mask, // mask word, 1 blocks
	input wire logic dsup_a_low, // digital supply below 1.8 V (level)
	input wire logic dsup_b_low, // digital supply below 2.7 V (level)
	input wire logic asup_low, // analog supply below threshold (level)
	input wire logic [2:0] mon_enable, // monitor powered: a, b, analog
	input wire logic result_write, // result register written (pulse)
	input wire logic result_read, // result register read (pulse)
	input wire logic fifo_thresh_hit, // fifo threshold slot written
	input wire logic fifo_access, // fifo register read or written
	input wire logic acc_full, // accumulator reached count
	input wire logic acc_access, // accumulator register read or written
	input wire logic upper_trip, // greater-than alarm tripped
	input wire logic lower_trip, // less-than alarm tripped
	input wire logic upper_thr_write, // upper alarm threshold written
	input wire logic lower_thr_write, // lower alarm threshold written
	input wire logic [3:0] analog_prog_pin, // analog pin levels, async
	input wire logic [3:0] digital_prog_pin, // digital pin levels, async
	input wire logic [15:0] pin_mode_field, // 4 bits per digital pin
	input wire logic [3:0] pin_logic_level, // output level per pin
	output logic [23:0] event_status, // status register contents
	output logic irq, // interrupt, active high
	output logic [3:0] pin_out, // digital pin drive value
	output logic [3:0] pin_oe, // digital pin drive enable
	output logic second_switch_ctrl // switch 2 control
);
	import sec_pkg::*;

	function automatic logic [3:0] mode_of(input logic [15:0] f,
		input int i);
		mode_of = f[i*MODE_W +: MODE_W];
	endfunction : mode_of

	logic [3:0] ap_s1_reg, ap_s2_reg, ap_s3_reg;
	logic [3:0] dp_s1_reg, dp_s2_reg, dp_s3_reg;
	logic [23:0] stat_reg, stat_next;
	logic [23:0] pend_reg, pend_next;
	logic in_read_reg, in_read_next;
	logic irq_reg, irq_next;
	logic [3:0] out_reg, out_next, oe_reg, oe_next;
	logic sw2_reg, sw2_next;
	logic ready_reg, ready_next;
	logic gap_seen_reg, gap_seen_next;
	logic [2:0] settle_reg, settle_next;
	logic [23:0] ev;
	logic [23:0] keep;

	// sync stage one is read only by stage two
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ap_s1_reg <= 4'h0;
			ap_s2_reg <= 4'h0;
			ap_s3_reg <= 4'h0;
			dp_s1_reg <= 4'h0;
			dp_s2_reg <= 4'h0;
			dp_s3_reg <= 4'h0;
			settle_reg <= 3'h0;
		end else begin
			ap_s1_reg <= analog_prog_pin; // RULE_22
			ap_s2_reg <= ap_s1_reg;
			ap_s3_reg <= ap_s2_reg;
			dp_s1_reg <= digital_prog_pin; // RULE_22
			dp_s2_reg <= dp_s1_reg;
			dp_s3_reg <= dp_s2_reg;
			settle_reg <= settle_next;
		end
	end

	// edges are ignored until the sync chain holds real pin levels, else a
	// pin idling high on its pull-up flags a rise after reset; limitation:
	// an edge before the first pin sample after reset is not reported
	always_comb begin
		settle_next = {settle_reg[1:0], 1'b1}; // RULE_22
	end

	// event vector in status bit order
	always_comb begin
		ev = 24'h00_0000;
		ev[BIT_DSUP_A] = dsup_a_low & mon_enable[0]; // RULE_11 RULE_12
		ev[BIT_DSUP_B] = dsup_b_low & mon_enable[1]; // RULE_12
		ev[BIT_ASUP] = asup_low & mon_enable[2]; // RULE_12
		ev[BIT_DONE] = result_write; // RULE_14
		ev[BIT_FIFO] = fifo_thresh_hit; // RULE_15
		ev[BIT_ACC] = acc_full; // RULE_16
		ev[BIT_UPPER] = upper_trip; // RULE_17
		ev[BIT_LOWER] = lower_trip; // RULE_17
		if (settle_reg[2]) begin
			ev[POS_AN_RISE +: NPIN] = ap_s2_reg & ~ap_s3_reg; // RULE_18
			ev[POS_AN_FALL +: NPIN] = ~ap_s2_reg & ap_s3_reg; // RULE_18
			ev[POS_DG_RISE +: NPIN] = dp_s2_reg & ~dp_s3_reg; // RULE_19
			ev[POS_DG_FALL +: NPIN] = ~dp_s2_reg & dp_s3_reg; // RULE_19
		end
	end

	// bits that survive a completed status read
	always_comb begin
		keep = 24'h00_0000;
		keep[BIT_DSUP_A] = dsup_a_low & mon_enable[0]; // RULE_11
		keep[BIT_DSUP_B] = dsup_b_low & mon_enable[1]; // RULE_11
		keep[BIT_ASUP] = asup_low & mon_enable[2]; // RULE_11
	end

	always_comb begin
		stat_next = stat_reg;
		pend_next = pend_reg;
		in_read_next = in_read_reg;
		irq_next = irq_reg;
		if (in_read_reg) begin
			// updates held so the host sees a frozen word
			pend_next = pend_reg | ev; // RULE_10
			// side clears still act during the read
			if (result_read) stat_next[BIT_DONE] = 1'b0; // RULE_14
			if (fifo_access) stat_next[BIT_FIFO] = 1'b0;
			if (acc_access) stat_next[BIT_ACC] = 1'b0;
			if (upper_thr_write) stat_next[BIT_UPPER] = 1'b0;
			if (lower_thr_write) stat_next[BIT_LOWER] = 1'b0;
			irq_next = 1'b0; // RULE_21
			if (stat_rd_end) begin
				stat_next = (stat_reg & keep) | pend_reg | ev; // RULE_09
				pend_next = 24'h00_0000;
				in_read_next = 1'b0;
				irq_next = |(((stat_reg & keep) | pend_reg | ev)
					& ~int_mask); // RULE_21
			end else if (stat_rd_abort) begin
				stat_next = stat_reg | pend_reg | ev;
				pend_next = 24'h00_0000;
				in_read_next = 1'b0;
				irq_next = |((stat_reg | pend_reg | ev)
					& ~int_mask); // RULE_21
			end
		end else begin
			stat_next = stat_reg;
			if (result_read) stat_next[BIT_DONE] = 1'b0;
			if (fifo_access) stat_next[BIT_FIFO] = 1'b0; // RULE_15
			if (acc_access) stat_next[BIT_ACC] = 1'b0; // RULE_16
			if (upper_thr_write) stat_next[BIT_UPPER] = 1'b0; // RULE_17
			if (lower_thr_write) stat_next[BIT_LOWER] = 1'b0;
			stat_next = stat_next | ev; // RULE_08 RULE_06
			irq_next = |(stat_next & ~int_mask); // RULE_07 RULE_20
			if (stat_rd_start) begin
				in_read_next = 1'b1;
				irq_next = 1'b0; // RULE_21
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stat_reg <= STATUS_POWERUP; // RULE_13
			pend_reg <= STATUS_RESET;
			in_read_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			stat_reg <= stat_next;
			pend_reg <= pend_next;
			in_read_reg <= in_read_next;
			irq_reg <= irq_next;
		end
	end

	// ready level is shared by every pin in ready mode
	always_comb begin
		ready_next = ready_reg;
		if (result_write) begin
			ready_next = ~ready_reg; // RULE_04
			if (!ready_reg) ready_next = 1'b1; // RULE_02
		end else if (!ready_reg && gap_seen_reg) begin
			ready_next = 1'b1; // RULE_04
		end
		if (result_read || (stat_rd_start && !in_read_reg))
			ready_next = 1'b0; // RULE_03
	end

	// marks a one-cycle drop so the pin can come back high
	always_comb begin
		gap_seen_next = result_write && ready_reg; // RULE_04
	end

	always_comb begin
		out_next = 4'h0;
		oe_next = 4'h0;
		sw2_next = 1'b0;
		for (int i = 0; i < NPIN; i++) begin
			if (mode_of(pin_mode_field, i) == MODE_READY) begin
				out_next[i] = ready_next;
				oe_next[i] = 1'b1;
			end else if (mode_of(pin_mode_field, i) == MODE_GEN_OUT) begin
				out_next[i] = pin_logic_level[i]; // RULE_05
				oe_next[i] = 1'b1;
			end else if (mode_of(pin_mode_field, i) == MODE_SWITCH2) begin
				// lowest-numbered pin in this mode wins
				if (!sw2_next) sw2_next = dp_s2_reg[i] | 1'b0; // RULE_01
			end
		end
		// second pass keeps priority explicit for the switch input
		for (int j = NPIN - 1; j >= 0; j--) begin
			if (mode_of(pin_mode_field, j) == MODE_SWITCH2)
				sw2_next = dp_s2_reg[j]; // RULE_01
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			out_reg <= 4'h0;
			oe_reg <= 4'h0;
			sw2_reg <= 1'b0;
			ready_reg <= 1'b0;
			gap_seen_reg <= 1'b0;
		end else begin
			out_reg <= out_next;
			oe_reg <= oe_next;
			sw2_reg <= sw2_next;
			ready_reg <= ready_next;
			gap_seen_reg <= gap_seen_next;
		end
	end

	assign event_status = stat_reg;
	assign irq = irq_reg;
	assign pin_out = out_reg;
	assign pin_oe = oe_reg;
	assign second_switch_ctrl = sw2_reg;

	a_recur_stays_set: assert property ( // RULE_08
		@(posedge ref_clk) disable iff (rst)
		(!in_read_reg && !stat_rd_start && result_write && !result_read)
		|=> stat_reg[BIT_DONE])
		else $error("done flag not set after result write");
	a_irq_unmasked: assert property ( // RULE_07
		@(posedge ref_clk) disable iff (rst)
		(!in_read_reg && !stat_rd_start && |(stat_next & ~int_mask))
		|=> irq_reg)
		else $error("unmasked status did not raise interrupt");
	a_irq_read_low: assert property ( // RULE_21
		@(posedge ref_clk) disable iff (rst)
		(in_read_reg && !stat_rd_end && !stat_rd_abort)
		|=> !irq_reg)
		else $error("interrupt high during status read");
	a_freeze_read: assert property ( // RULE_10
		@(posedge ref_clk) disable iff (rst)
		(in_read_reg && !stat_rd_end && !stat_rd_abort)
		|=> (stat_reg & ~$past(stat_reg)) == 24'h00_0000)
		else $error("status gained bits during read");
	a_clear_read: assert property ( // RULE_09
		@(posedge ref_clk) disable iff (rst)
		(in_read_reg && stat_rd_end && ev == 24'h00_0000
		&& pend_reg == 24'h00_0000 && keep == 24'h00_0000)
		|=> stat_reg == 24'h00_0000)
		else $error("status not cleared by read");
	a_mon_off_hold: assert property ( // RULE_12
		@(posedge ref_clk) disable iff (rst)
		(!mon_enable[2] && !stat_reg[BIT_ASUP] && !in_read_reg)
		|=> !stat_reg[BIT_ASUP])
		else $error("powered-down monitor flag set");
	a_genout_level: assert property ( // RULE_05
		@(posedge ref_clk) disable iff (rst)
		(mode_of(pin_mode_field, 0) == MODE_GEN_OUT)
		|=> pin_out[0] == $past(pin_logic_level[0]) && pin_oe[0])
		else $error("output pin not following level bit");
	a_ready_clear: assert property ( // RULE_03
		@(posedge ref_clk) disable iff (rst)
		(result_read && !result_write) |=> !ready_reg)
		else $error("ready not low after result read");
	a_rise_flag: assert property ( // RULE_19
		@(posedge ref_clk) disable iff (rst)
		(!in_read_reg && !stat_rd_start && settle_reg[2]
		&& dp_s2_reg[0] && !dp_s3_reg[0])
		|=> stat_reg[POS_DG_RISE])
		else $error("digital rise edge not flagged");
	a_ready_drop: assert property ( // RULE_04
		@(posedge ref_clk) disable iff (rst)
		(result_write && ready_reg && !result_read) |=> !ready_reg)
		else $error("ready did not drop on new result");
	a_ready_back: assert property ( // RULE_04
		@(posedge ref_clk) disable iff (rst)
		(gap_seen_reg && !ready_reg && !result_read
		&& !(stat_rd_start && !in_read_reg)) |=> ready_reg)
		else $error("ready did not return high after gap");
	a_switch_input: assert property ( // RULE_01
		@(posedge ref_clk) disable iff (rst)
		(mode_of(pin_mode_field, 2) == MODE_SWITCH2) |=> !pin_oe[2])
		else $error("switch input pin is being driven");
endmodule : sec_collector

// file: sec_host_model.sv
// Purpose: host side that frames status register reads
// Assumes: one read at a time, four cycles from start to finish
// Notes: abort_sel ends the read by abort instead of completion
`timescale 1ns/1ps
module sec_host_model (
	input wire logic ref_clk, // system clock
	input wire logic rst, // synchronous reset
	input wire logic go, // begin a status read
	input wire logic abort_sel, // finish by abort
	output logic stat_rd_start, // read start pulse
	output logic stat_rd_end, // read end pulse
	output logic stat_rd_abort, // read abort pulse
	output logic busy // read in progress
);
	logic [2:0] cnt;
	always @(posedge ref_clk) begin
		stat_rd_start <= 1'b0;
		stat_rd_end <= 1'b0;
		stat_rd_abort <= 1'b0;
		if (rst) begin
			busy <= 1'b0;
			cnt <= 3'h0;
		end else if (go && !busy) begin
			// no nested start: go is ignored while busy
			stat_rd_start <= 1'b1;
			busy <= 1'b1;
			cnt <= 3'h4;
		end else if (busy) begin
			cnt <= cnt - 3'h1;
			if (cnt == 3'h1) begin
				busy <= 1'b0;
				stat_rd_abort <= abort_sel;
				stat_rd_end <= !abort_sel;
			end
		end
	end
endmodule : sec_host_model

// file: sec_collector_tb.sv
// Purpose: self-checking bench for the status event collector
// Assumes: events are one-cycle pulses driven on the rising edge
// Notes: ev bits map to result, fifo, acc, upper and lower pulses
`timescale 1ns/1ps
module sec_collector_tb;
	import sec_pkg::*;
	logic ref_clk = 0, rst = 1, go = 0, ab = 0;
	logic [9:0] ev = '0;
	logic [23:0] int_mask = MASK_RESET;
	logic [2:0] sup = '0, mon_enable = 3'h7;
	logic [3:0] apin = '0, dpin = '0, lvl = '0;
	logic [15:0] mode = '0;
	logic rs, re, ra, busy, irq, sw2;
	logic [23:0] stat;
	logic [3:0] pin_out, pin_oe;
	int mismatches = 0, tests_run = 0, cyc = 0, i, lows;
	always #5 ref_clk = ~ref_clk;
	sec_host_model u_host (.ref_clk(ref_clk), .rst(rst), .go(go),
		.abort_sel(ab), .stat_rd_start(rs), .stat_rd_end(re),
		.stat_rd_abort(ra), .busy(busy));
	sec_collector u_dut (.ref_clk(ref_clk), .rst(rst), .stat_rd_start(rs),
		.stat_rd_end(re), .stat_rd_abort(ra), .int_mask(int_mask),
		.dsup_a_low(sup[0]), .dsup_b_low(sup[1]), .asup_low(sup[2]),
		.mon_enable(mon_enable), .result_write(ev[0]), .result_read(ev[1]),
		.fifo_thresh_hit(ev[2]), .fifo_access(ev[3]), .acc_full(ev[4]),
		.acc_access(ev[5]), .upper_trip(ev[6]), .upper_thr_write(ev[7]),
		.lower_trip(ev[8]), .lower_thr_write(ev[9]),
		.analog_prog_pin(apin), .digital_prog_pin(dpin),
		.pin_mode_field(mode), .pin_logic_level(lvl), .event_status(stat),
		.irq(irq), .pin_out(pin_out), .pin_oe(pin_oe),
		.second_switch_ctrl(sw2));
	task check(input logic [23:0] seen, input logic [23:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task pulse(input int b);
		@(posedge ref_clk);
		ev[b] <= 1'b1;
		@(posedge ref_clk);
		ev[b] <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : pulse
	task host_read(input logic a, input int mid);
		@(posedge ref_clk);
		go <= 1'b1;
		ab <= a;
		@(posedge ref_clk);
		go <= 1'b0;
		@(posedge ref_clk);
		if (mid >= 0) begin
			ev[mid] <= 1'b1;
			@(posedge ref_clk);
			ev[mid] <= 1'b0;
			#1;
			check(irq, 0);
		end
		for (int k = 0; k < 20 && busy; k++) @(posedge ref_clk);
		repeat (3) @(posedge ref_clk);
		#1;
	endtask : host_read
	task t_flags;
		check(stat, STATUS_POWERUP);
		host_read(0, -1);
		check(stat, 24'h00_0000);
		pulse(0);
		check(stat, 24'h10_0000);
		check(irq, 0);
		@(posedge ref_clk);
		int_mask <= ~(24'h00_0001 << BIT_DONE);
		pulse(0);
		check(stat, 24'h10_0000);
		check(irq, 1);
		pulse(1);
		check(stat, 24'h00_0000);
		@(posedge ref_clk);
		int_mask <= ~(24'h00_0001 << BIT_FIFO);
		host_read(0, 2);
		check(stat, 24'h08_0000);
		check(irq, 1);
		pulse(3);
		check(stat, 24'h00_0000);
		@(posedge ref_clk);
		int_mask <= MASK_RESET;
		// acc, upper, lower: each set pulse followed by its side clear
		for (i = 0; i < 3; i++) begin
			pulse(4 + 2 * i);
			check(stat, 24'h04_0000 >> i);
			pulse(5 + 2 * i);
			check(stat, 24'h00_0000);
		end
		pulse(4);
		host_read(1, -1);
		check(stat, 24'h04_0000);
		host_read(0, -1);
		check(stat, 24'h00_0000);
		$display("test flags done");
	endtask : t_flags
	task t_supply;
		@(posedge ref_clk);
		sup <= 3'h4;
		pulse(1);
		check(stat, 24'h20_0000);
		host_read(0, -1);
		check(stat, 24'h20_0000);
		@(posedge ref_clk);
		sup <= 3'h0;
		host_read(0, -1);
		check(stat, 24'h00_0000);
		@(posedge ref_clk);
		mon_enable <= 3'h3;
		sup <= 3'h4;
		pulse(1);
		check(stat, 24'h00_0000);
		@(posedge ref_clk);
		sup <= 3'h0;
		mon_enable <= 3'h7;
		$display("test supply done");
	endtask : t_supply
	task t_pins;
		@(posedge ref_clk);
		dpin <= 4'h1;
		repeat (6) @(posedge ref_clk);
		dpin <= 4'h0;
		apin <= 4'h8;
		repeat (6) @(posedge ref_clk);
		apin <= 4'h0;
		pulse(1);
		repeat (4) @(posedge ref_clk);
		#1;
		check(stat, 24'h00_8811);
		host_read(0, -1);
		// pin3 ready, pin2 switch input, pins 1 and 0 general output
		@(posedge ref_clk);
		mode <= {MODE_READY, MODE_SWITCH2, MODE_GEN_OUT, MODE_GEN_OUT};
		lvl <= 4'h2;
		dpin <= 4'h4;
		pulse(1);
		repeat (4) @(posedge ref_clk);
		#1;
		check({pin_oe[2:0], pin_out[1:0], sw2}, 24'h1D);
		pulse(0);
		check(pin_out[3], 1);
		lows = 0;
		@(posedge ref_clk);
		ev[0] <= 1'b1;
		for (i = 0; i < 6; i++) begin
			@(posedge ref_clk);
			ev[0] <= 1'b0;
			#1;
			lows += !pin_out[3];
		end
		check(24'(lows), 24'h1);
		pulse(1);
		check(pin_out[3], 0);
		pulse(0);
		check(pin_out[3], 1);
		host_read(0, -1);
		check(pin_out[3], 0);
		$display("test pins done");
	endtask : t_pins
	task end_sim;
		$display("counts: %0d compared, %0d mismatched", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			mismatches++;
			end_sim();
		end
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		t_flags();
		t_supply();
		t_pins();
		end_sim();
	end
endmodule : sec_collector_tb
